// ===== design/tcc_pkg.sv
// constants and types shared by the timer channel counter core
// assumes every user writes tcc_pkg::name, nothing imported
`default_nettype none
package tcc_pkg;
	localparam int CNT_W = 16;
	localparam int PRESC_W = 15;
	localparam int FILT_DEPTH = 3;
	localparam logic [15:0] CNT_ZERO = 16'h0000;
	localparam logic [15:0] CNT_FULL = 16'hffff;
	localparam logic [15:0] CNT_RESET = 16'h0000;
	localparam logic [15:0] DATA_RESET = 16'h0000;
	localparam logic [1:0] EDGE_FALL = 2'h0;
	localparam logic [1:0] EDGE_RISE = 2'h1;
	localparam logic [1:0] EDGE_BOTH = 2'h2;

	typedef enum logic [2:0]
	{
		MODE_INTERVAL = 3'h0,
		MODE_EVENT = 3'h1,
		MODE_CAPTURE = 3'h2,
		MODE_ONECOUNT = 3'h3,
		MODE_CAPONE = 3'h4
	} tcc_mode_t;

	// gray along stop -> arm -> run
	typedef enum logic [1:0]
	{
		ST_STOP = 2'h0,
		ST_ARM = 2'h1,
		ST_RUN = 2'h3
	} tcc_state_t;
endpackage
`default_nettype wire

// ===== design/tcc_edge_if.sv
// edge detector hookup between the counter core and its input sampler
// assumes one clock domain, ref_clk
`timescale 1ns/1ps
`default_nettype none
interface tcc_edge_if;
	logic opClkEn;
	logic pin;
	logic filterEn;
	logic rise;
	logic fall;
	modport det (input opClkEn, input pin, input filterEn,
		output rise, output fall);
	modport core (output opClkEn, output pin, output filterEn,
		input rise, input fall);
endinterface
`default_nettype wire

// ===== design/tcc_edge_detect.sv
// input pin sampler on the operation clock with optional noise filter
// assumes pin already synchronous to ref_clk, reset already synchronised
`timescale 1ns/1ps
`default_nettype none
module tcc_edge_detect
(
	input wire logic ref_clk,
	input wire logic rstSyncN,
	tcc_edge_if.det edgeIf
);
	localparam int FD = tcc_pkg::FILT_DEPTH;
	logic [FD-1:0] sampleQ;
	logic filtQ;
	logic filtD;
	logic prevQ;
	logic levelNow;
	logic allHigh;
	logic [FD-1:0] sampleD;
	logic nextHigh;
	logic nextLow;
	logic filtPick;

	assign allHigh = &sampleQ;
	assign sampleD = {sampleQ[FD-2:0], edgeIf.pin};
	assign nextHigh = &sampleD;
	assign nextLow = ~|sampleD;
	// decided on the tick itself, so the filter costs exactly two ticks
	assign filtPick = nextHigh ? 1'b1 : (nextLow ? 1'b0 : filtQ); // [RQ14]
	assign filtD = edgeIf.opClkEn ? filtPick : filtQ; // [RQ14]
	assign levelNow = edgeIf.filterEn ? filtQ : sampleQ[0];
	// level changes only just after a tick, so these are one-cycle
	assign edgeIf.rise = levelNow & ~prevQ; // [RQ18]
	assign edgeIf.fall = ~levelNow & prevQ; // [RQ18]

	always_ff @(posedge ref_clk or negedge rstSyncN)
	begin
		if (!rstSyncN)
		begin
			sampleQ <= '0;
			filtQ <= 1'b0;
			prevQ <= 1'b0;
		end
		else
		begin
			if (edgeIf.opClkEn)
				sampleQ <= sampleD; // [RQ18]
			filtQ <= filtD;
			prevQ <= levelNow;
		end
	end

	a_filter_rise_agree: assert property (@(posedge ref_clk) // [RQ14]
		disable iff (!rstSyncN)
		(edgeIf.filterEn && edgeIf.rise) |-> allHigh)
		else $error("filtered rise without agreeing samples");
	a_rise_single: assert property (@(posedge ref_clk) // [RQ16]
		disable iff (!rstSyncN)
		edgeIf.rise |=> !edgeIf.rise)
		else $error("rise pulse longer than one cycle");
endmodule
`default_nettype wire

// ===== design/tcc_timer_channel.sv
// counter core of one timer channel, five counting modes
// assumes control strobes are one-cycle pulses synchronous to ref_clk
// What this block does
// [RQ1] start write sets enabled flag; interval/capture count holds until next count clock
// [RQ2] interval/capture: first count clock makes start trigger, optional irq
// [RQ3] interval: first count clock loads data, later clocks decrement
// [RQ4] interval: count clock at zero raises irq, reloads, keeps counting
// [RQ5] event: count holds stopped; start write loads data at once
// [RQ6] event: with source select on edges, each valid input edge decrements the count, or at zero raises irq and reloads data
// [RQ7] capture: start trigger loads zero, later clocks increment
// [RQ8] capture: valid edge captures count, raises irq, restarts at zero
// [RQ9] one-count modes: start write enters wait for rising input edge
// [RQ10] one-count: trigger loads data, then decrement per count clock
// [RQ11] one-count: at zero raise irq, force all ones, wait next trigger
// [RQ12] capture one-count: rising edge trigger loads zero, then increments
// [RQ13] capture one-count: falling edge captures count and raises irq
// [RQ14] noise filter adds two operation clocks of edge delay
// [RQ15] interval/capture first period may run one count clock long
// [RQ16] operation clock (prescaleDiv above 0), start strobe and irq are one-cycle pulses
// [RQ17] outside capture modes, source select picks operation clock or input edges as count clock
// [RQ18] input edges sampled by operation clock, one to two periods lag
// [RQ19] count and data registers sixteen bits; data reloads or captures
`timescale 1ns/1ps
`default_nettype none
module tcc_timer_channel
#(
	parameter int CNT_W = tcc_pkg::CNT_W,
	parameter int PRESC_W = tcc_pkg::PRESC_W
)
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic channelStartBit,
	input wire logic channelStopBit,
	input wire logic [2:0] modeSel,
	input wire logic startIrqSelect,
	input wire logic countSourceSelect,
	input wire logic [1:0] validEdgeSel,
	input wire logic noiseFilterEn,
	input wire logic [PRESC_W-1:0] prescaleDiv,
	input wire logic dataWrEn,
	input wire logic [CNT_W-1:0] dataWrValue,
	input wire logic timerInputPin,
	output logic [CNT_W-1:0] countValueReg,
	output logic [CNT_W-1:0] reloadCaptureReg,
	output logic channelEnabledFlag,
	output logic channelIrq,
	output logic startTrigStrobe,
	output logic opClkEn
);
	// refused at elaboration: counter logic needs at least two bits
	if (CNT_W < 2 || PRESC_W < 1)
	begin
		$error("tcc_timer_channel: unsupported width");
	end

	function automatic logic isOneShot(input tcc_pkg::tcc_mode_t m);
		isOneShot = (m == tcc_pkg::MODE_ONECOUNT) ||
			(m == tcc_pkg::MODE_CAPONE);
	endfunction

	function automatic logic isCapture(input tcc_pkg::tcc_mode_t m);
		isCapture = (m == tcc_pkg::MODE_CAPTURE) ||
			(m == tcc_pkg::MODE_CAPONE);
	endfunction

	// reset release through two flops
	logic [1:0] rstPipeQ;
	logic rstSyncN;

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			rstPipeQ <= 2'h0;
		else
			rstPipeQ <= {rstPipeQ[0], 1'b1};
	end
	assign rstSyncN = rstPipeQ[1];

	// operation clock: one-cycle enable every prescaleDiv+1 cycles
	logic [PRESC_W-1:0] prescQ;
	logic opClkQ;
	logic prescWrap;

	assign prescWrap = (prescQ >= prescaleDiv);

	always_ff @(posedge ref_clk or negedge rstSyncN)
	begin
		if (!rstSyncN)
		begin
			prescQ <= '0;
			opClkQ <= 1'b0;
		end
		else
		begin
			prescQ <= prescWrap ? '0 : prescQ + 1'b1;
			opClkQ <= prescWrap; // [RQ16]
		end
	end
	assign opClkEn = opClkQ;

	tcc_edge_if edgeIf ();
	assign edgeIf.opClkEn = opClkQ;
	assign edgeIf.pin = timerInputPin;
	assign edgeIf.filterEn = noiseFilterEn;

	tcc_edge_detect uEdge
	(
		.ref_clk(ref_clk),
		.rstSyncN(rstSyncN),
		.edgeIf(edgeIf.det)
	);

	tcc_pkg::tcc_mode_t modeV;
	logic validEdge;
	logic countClk;
	logic pinRise;
	logic pinFall;

	assign modeV = tcc_pkg::tcc_mode_t'(modeSel);
	assign pinRise = edgeIf.rise;
	assign pinFall = edgeIf.fall;
	assign validEdge = (validEdgeSel == tcc_pkg::EDGE_RISE) ? pinRise :
		(validEdgeSel == tcc_pkg::EDGE_FALL) ? pinFall :
		(validEdgeSel == tcc_pkg::EDGE_BOTH) ? (pinRise | pinFall) :
		1'b0;
	// capture modes time with the operation clock; edges are captures
	assign countClk = (countSourceSelect && !isCapture(modeV)) ?
		validEdge : opClkQ; // [RQ17]

	tcc_pkg::tcc_state_t stateQ;
	tcc_pkg::tcc_state_t stateD;
	logic [CNT_W-1:0] countQ;
	logic [CNT_W-1:0] countD;
	logic [CNT_W-1:0] dataQ;
	logic [CNT_W-1:0] dataD;
	logic irqQ;
	logic irqD;
	logic trigQ;
	logic trigD;
	logic countIsZero;

	assign countIsZero = (countQ == '0);

	always_comb
	begin
		stateD = stateQ;
		countD = countQ;
		dataD = dataWrEn ? dataWrValue : dataQ;
		irqD = 1'b0;
		trigD = 1'b0;
		if (channelStopBit)
			stateD = tcc_pkg::ST_STOP;
		else
		begin
			case (stateQ)
				tcc_pkg::ST_STOP:
				begin
					if (channelStartBit && modeV == tcc_pkg::MODE_EVENT)
					begin
						countD = dataQ; // [RQ5]
						stateD = tcc_pkg::ST_RUN; // [RQ1]
					end
					else if (channelStartBit)
						stateD = tcc_pkg::ST_ARM; // [RQ1] [RQ9]
				end
				tcc_pkg::ST_ARM:
				begin
					if (isOneShot(modeV))
					begin
						if (pinRise)
						begin
							trigD = 1'b1;
							countD = (modeV == tcc_pkg::MODE_ONECOUNT) ?
								dataQ : '0; // [RQ10] [RQ12]
							stateD = tcc_pkg::ST_RUN;
						end
					end
					else if (modeV == tcc_pkg::MODE_EVENT)
					begin
						countD = dataQ; // [RQ5]
						stateD = tcc_pkg::ST_RUN;
					end
					// waiting for the count clock stretches period one [RQ15]
					else if (countClk)
					begin
						trigD = 1'b1; // [RQ2]
						irqD = startIrqSelect; // [RQ2]
						countD = (modeV == tcc_pkg::MODE_INTERVAL) ?
							dataQ : '0; // [RQ3] [RQ7]
						stateD = tcc_pkg::ST_RUN;
					end
				end
				tcc_pkg::ST_RUN:
				begin
					case (modeV)
						tcc_pkg::MODE_INTERVAL, tcc_pkg::MODE_EVENT:
						begin
							if (countClk && countIsZero)
							begin
								irqD = 1'b1; // [RQ4]
								countD = dataQ; // [RQ4] [RQ19]
							end
							else if (countClk)
								countD = countQ - 1'b1; // [RQ3] [RQ6]
						end
						tcc_pkg::MODE_CAPTURE:
						begin
							if (validEdge)
							begin
								dataD = countQ; // [RQ8] [RQ19]
								irqD = 1'b1; // [RQ8]
								countD = '0; // [RQ8]
							end
							else if (countClk)
								countD = countQ + 1'b1; // [RQ7]
						end
						tcc_pkg::MODE_ONECOUNT:
						begin
							if (countClk && countIsZero)
							begin
								irqD = 1'b1; // [RQ11]
								countD = '1; // [RQ11]
								stateD = tcc_pkg::ST_ARM; // [RQ11]
							end
							else if (countClk)
								countD = countQ - 1'b1; // [RQ10]
						end
						tcc_pkg::MODE_CAPONE:
						begin
							// count holds after capture until next rise
							if (pinFall)
							begin
								dataD = countQ; // [RQ13]
								irqD = 1'b1; // [RQ13]
								stateD = tcc_pkg::ST_ARM;
							end
							else if (countClk)
								countD = countQ + 1'b1; // [RQ12]
						end
						default:
							stateD = tcc_pkg::ST_STOP;
					endcase
				end
				default:
					stateD = tcc_pkg::ST_STOP;
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge rstSyncN)
	begin
		if (!rstSyncN)
		begin
			stateQ <= tcc_pkg::ST_STOP;
			countQ <= CNT_W'(tcc_pkg::CNT_RESET);
			dataQ <= CNT_W'(tcc_pkg::DATA_RESET);
			irqQ <= 1'b0;
			trigQ <= 1'b0;
		end
		else
		begin
			stateQ <= stateD;
			countQ <= countD;
			dataQ <= dataD;
			irqQ <= irqD; // [RQ16]
			trigQ <= trigD; // [RQ16]
		end
	end

	assign countValueReg = countQ;
	assign reloadCaptureReg = dataQ;
	assign channelEnabledFlag = (stateQ != tcc_pkg::ST_STOP);
	assign channelIrq = irqQ;
	assign startTrigStrobe = trigQ;

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rstSyncN);

	logic armCount;
	assign armCount = (modeV == tcc_pkg::MODE_INTERVAL) ||
		(modeV == tcc_pkg::MODE_CAPTURE);

	sequence sOneArmRise;
		stateQ == tcc_pkg::ST_ARM && modeV == tcc_pkg::MODE_ONECOUNT &&
			pinRise && !channelStopBit;
	endsequence
	sequence sOneLoaded;
		startTrigStrobe && stateQ == tcc_pkg::ST_RUN &&
			countQ == $past(dataQ);
	endsequence

	a_start_enables: assert property ( // [RQ1]
		(channelStartBit && !channelStopBit && !channelEnabledFlag)
		|=> channelEnabledFlag)
		else $error("start write did not enable channel");
	a_arm_holds: assert property ( // [RQ1]
		(stateQ == tcc_pkg::ST_ARM && armCount && !countClk &&
		!channelStopBit) |=> (countQ == $past(countQ)))
		else $error("count moved before first count clock");
	a_first_trigger: assert property ( // [RQ2]
		(stateQ == tcc_pkg::ST_ARM && armCount && countClk &&
		!channelStopBit) |=> (startTrigStrobe &&
		channelIrq == $past(startIrqSelect)))
		else $error("first count clock gave no start trigger");
	a_interval_reload: assert property ( // [RQ4]
		(stateQ == tcc_pkg::ST_RUN && modeV == tcc_pkg::MODE_INTERVAL &&
		countClk && countIsZero && !channelStopBit)
		|=> (channelIrq && countQ == $past(dataQ)))
		else $error("interval zero did not reload with irq");
	a_event_load: assert property ( // [RQ5]
		(channelStartBit && !channelStopBit && !channelEnabledFlag &&
		modeV == tcc_pkg::MODE_EVENT)
		|=> (countQ == $past(dataQ) && stateQ == tcc_pkg::ST_RUN))
		else $error("event start did not load data at once");
	a_capture_edge: assert property ( // [RQ8]
		(stateQ == tcc_pkg::ST_RUN && modeV == tcc_pkg::MODE_CAPTURE &&
		validEdge && !channelStopBit)
		|=> (channelIrq && dataQ == $past(countQ) && countQ == '0))
		else $error("capture edge mishandled");
	a_one_trigger: assert property ( // [RQ10]
		sOneArmRise |=> sOneLoaded)
		else $error("one-count trigger did not load data");
	a_one_end: assert property ( // [RQ11]
		(stateQ == tcc_pkg::ST_RUN && modeV == tcc_pkg::MODE_ONECOUNT &&
		countClk && countIsZero && !channelStopBit)
		|=> (channelIrq && countQ == '1 && stateQ == tcc_pkg::ST_ARM))
		else $error("one-count end mishandled");
	a_capone_fall: assert property ( // [RQ13]
		(stateQ == tcc_pkg::ST_RUN && modeV == tcc_pkg::MODE_CAPONE &&
		pinFall && !channelStopBit)
		|=> (channelIrq && dataQ == $past(countQ)))
		else $error("high width not captured");
	a_event_step: assert property ( // [RQ6]
		(stateQ == tcc_pkg::ST_RUN && modeV == tcc_pkg::MODE_EVENT &&
		countClk && !countIsZero && !channelStopBit)
		|=> (countQ == $past(countQ) - 1'b1))
		else $error("event edge did not decrement count");
	a_wait_holds: assert property ( // [RQ9]
		(stateQ == tcc_pkg::ST_ARM && isOneShot(modeV) && !pinRise &&
		!channelStopBit) |=> (countQ == $past(countQ)))
		else $error("count moved while waiting for trigger");
	a_capone_start: assert property ( // [RQ12]
		(stateQ == tcc_pkg::ST_ARM && modeV == tcc_pkg::MODE_CAPONE &&
		pinRise && !channelStopBit)
		|=> (startTrigStrobe && countQ == '0))
		else $error("high width count did not start at zero");
	a_pulses_single: assert property ( // [RQ16]
		(startTrigStrobe || (opClkEn && prescaleDiv != '0))
		|=> !(startTrigStrobe && $past(startTrigStrobe)) &&
		!(opClkEn && $past(prescaleDiv) != '0 && $past(opClkEn)))
		else $error("strobe held longer than one cycle");
endmodule
`default_nettype wire

// ===== test/tcc_pin_model.sv
// partner: drives the timer input pin with high pulses of a given width
// assumes requests set at falling edges and held for one cycle
`timescale 1ns/1ps
`default_nettype none
module tcc_pin_model
(
	input wire logic ref_clk,
	input wire logic pulseReq,
	input wire logic [7:0] highLen,
	output logic pin = 1'b0
);
	logic reqSeen = 1'b0;
	logic [7:0] left = 8'h00;
	always @(posedge ref_clk)
		reqSeen <= pulseReq;
	// pin moves on falling edges only, away from the design sampling edge
	always @(negedge ref_clk)
	begin
		if (reqSeen)
		begin
			pin <= 1'b1;
			left <= highLen;
		end
		else if (left > 8'h01)
			left <= left - 8'h01;
		else
		begin
			pin <= 1'b0;
			left <= 8'h00;
		end
	end
endmodule
`default_nettype wire

// ===== test/tcc_timer_channel_tb.sv
// bench for the timer channel counter core, one task per scenario
// assumes prescaleDiv of 0 or 1 keeps every wait short
`timescale 1ns/1ps
`default_nettype none
module tcc_timer_channel_tb;
	logic ref_clk = 1'b0, rst_n = 1'b0, channelStartBit = 1'b0;
	logic channelStopBit = 1'b0, startIrqSelect = 1'b0;
	logic countSourceSelect = 1'b0, noiseFilterEn = 1'b0;
	logic dataWrEn = 1'b0, pulseReq = 1'b0, timerInputPin;
	logic [2:0] modeSel = 3'h0;
	logic [1:0] validEdgeSel = 2'h1;
	logic [14:0] prescaleDiv = 15'h0000;
	logic [15:0] dataWrValue = 16'h0000;
	logic [7:0] highLen = 8'h01;
	logic [15:0] countValueReg, reloadCaptureReg;
	logic channelEnabledFlag, channelIrq, startTrigStrobe, opClkEn;
	int num_errors = 0;
	int n_tests = 0;

	tcc_timer_channel DUT (.ref_clk(ref_clk), .rst_n(rst_n),
		.channelStartBit(channelStartBit), .channelStopBit(channelStopBit),
		.modeSel(modeSel), .startIrqSelect(startIrqSelect),
		.countSourceSelect(countSourceSelect), .validEdgeSel(validEdgeSel),
		.noiseFilterEn(noiseFilterEn), .prescaleDiv(prescaleDiv),
		.dataWrEn(dataWrEn), .dataWrValue(dataWrValue),
		.timerInputPin(timerInputPin), .countValueReg(countValueReg),
		.reloadCaptureReg(reloadCaptureReg),
		.channelEnabledFlag(channelEnabledFlag), .channelIrq(channelIrq),
		.startTrigStrobe(startTrigStrobe), .opClkEn(opClkEn));
	tcc_pin_model partner (.ref_clk(ref_clk), .pulseReq(pulseReq),
		.highLen(highLen), .pin(timerInputPin));

	initial
	begin
		forever #2.5 ref_clk = ~ref_clk;
	end

	task automatic summarize;
		$display("checks %0d errors %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic chk(input string what, input logic [15:0] seen,
		input logic [15:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// bounded wait for irq (1) or start strobe (0), sampled at negedge
	task automatic waitOn(input bit irq, output int n);
		n = 0;
		do
		begin
			@(negedge ref_clk);
			n++;
		end
		while (((irq ? channelIrq : startTrigStrobe) !== 1'b1) && n < 300);
		chk("wait", 16'(n < 300), 16'h0001);
	endtask

	task automatic pulse(input logic [7:0] len);
		highLen = len;
		pulseReq = 1'b1;
		@(negedge ref_clk);
		pulseReq = 1'b0;
	endtask

	// stop, load data, then start in mode m
	task automatic go(input logic [2:0] m, input logic [15:0] d);
		channelStopBit = 1'b1;
		dataWrEn = 1'b1;
		dataWrValue = d;
		@(negedge ref_clk);
		channelStopBit = 1'b0;
		dataWrEn = 1'b0;
		modeSel = m;
		channelStartBit = 1'b1;
		@(negedge ref_clk);
		channelStartBit = 1'b0;
		chk("enabled", channelEnabledFlag, 16'h0001);
	endtask

	task automatic testInterval;
		int n;
		logic opPrev;
		prescaleDiv = 15'h0001;
		startIrqSelect = 1'b1;
		go(tcc_pkg::MODE_INTERVAL, 16'h0003);
		waitOn(1'b0, n);
		chk("trig irq", channelIrq, 16'h0001);
		chk("first load", countValueReg, 16'h0003);
		repeat (2)
		begin
			waitOn(1'b1, n);
			chk("period", 16'(n), 16'd8);
			chk("reload", countValueReg, 16'h0003);
		end
		// divide by two: the enable must alternate every cycle
		opPrev = opClkEn;
		@(negedge ref_clk);
		chk("opclk pulse", {15'h0000, opPrev ^ opClkEn}, 16'h0001);
		prescaleDiv = 15'h0000;
		startIrqSelect = 1'b0;
		$display("test interval done");
	endtask

	task automatic testEvent;
		int lat[2];
		logic [15:0] c;
		countSourceSelect = 1'b1;
		go(tcc_pkg::MODE_EVENT, 16'h0005);
		chk("event load", countValueReg, 16'h0005);
		for (int f = 0; f < 2; f++)
		begin
			noiseFilterEn = f[0];
			pulse(8'h04);
			c = countValueReg;
			lat[f] = 0;
			while (countValueReg === c && lat[f] < 50)
			begin
				@(negedge ref_clk);
				lat[f]++;
			end
			repeat (8) @(negedge ref_clk);
		end
		chk("event count", countValueReg, 16'h0003);
		chk("filter lag", 16'(lat[1] - lat[0]), 16'd2);
		noiseFilterEn = 1'b0;
		validEdgeSel = tcc_pkg::EDGE_BOTH;
		pulse(8'h04);
		repeat (10) @(negedge ref_clk);
		chk("both edges", countValueReg, 16'h0001);
		validEdgeSel = tcc_pkg::EDGE_FALL;
		pulse(8'h04);
		repeat (10) @(negedge ref_clk);
		chk("fall edge", countValueReg, 16'h0000);
		validEdgeSel = tcc_pkg::EDGE_RISE;
		countSourceSelect = 1'b0;
		$display("test event done");
	endtask

	task automatic testCapture;
		int n;
		go(tcc_pkg::MODE_CAPTURE, 16'h0000);
		waitOn(1'b0, n);
		chk("cap start", countValueReg, 16'h0000);
		for (int i = 0; i < 2; i++)
		begin
			pulse(8'h03);
			waitOn(1'b1, n);
			chk("cap restart", countValueReg, 16'h0000);
			repeat (9 - n) @(negedge ref_clk);
		end
		chk("cap value", reloadCaptureReg, 16'd9);
		$display("test capture done");
	endtask

	task automatic testOneCount;
		int n;
		logic [15:0] c;
		c = countValueReg;
		go(tcc_pkg::MODE_ONECOUNT, 16'h0004);
		repeat (4) @(negedge ref_clk);
		chk("wait hold", countValueReg, c);
		pulse(8'h02);
		waitOn(1'b0, n);
		chk("one load", countValueReg, 16'h0004);
		waitOn(1'b1, n);
		chk("one len", 16'(n), 16'd5);
		repeat (3) @(negedge ref_clk);
		chk("one stop", countValueReg, 16'hffff);
		$display("test one-count done");
	endtask

	task automatic testCapOne;
		int n;
		go(tcc_pkg::MODE_CAPONE, 16'h0000);
		pulse(8'h0c);
		waitOn(1'b0, n);
		chk("width start", countValueReg, 16'h0000);
		waitOn(1'b1, n);
		chk("width time", 16'(n), 16'd12);
		chk("width value", reloadCaptureReg, 16'd11);
		$display("test capture one-count done");
	endtask

	initial
	begin
		repeat (8) @(negedge ref_clk);
		rst_n = 1'b1;
		repeat (4) @(negedge ref_clk);
		testInterval();
		testEvent();
		testCapture();
		testOneCount();
		testCapOne();
		summarize();
	end

	// whole run needs well under a thousand cycles
	initial
	begin
		repeat (5000) @(posedge ref_clk);
		num_errors++;
		summarize();
	end
endmodule
`default_nettype wire
